// ### swcore_pkg.sv
// Constants and types for the switch core buffering datapath
// ----------------------------------------------------------------------
// Summary of operation
// - Six x4 ports, port 0 upstream
// - Even port merges with next odd port
// - Downstream bus and upstream bus run concurrently
// - Peer traffic goes via decoupler queue
// - Four input queues per port
// - Admission limited by bytes and TLP count
// - Posted/completion: 4 KB or 32 TLPs
// - Non-posted: 768 bytes or 32 TLPs
// - Merged ports double queue limits
// - Insertion buffer never merged or resized
// - Insertion buffer: 12 doublewords, two TLPs
// - Output buffer split per port when bifurcated
// - Output buffer holds TLPs until acknowledged
// - Output buffer 4 KB, 8 KB merged, 32 TLPs
// - Decoupler holds one 2112-byte TLP
// - 66-bit beats with even doubleword parity
// - Bifurcated: even cycles even port, odd odd
// - Narrow links leave their slots idle
// - Merged stack uses every cycle
// - Core demultiplexes beats into port queues
// - Core moves TLPs contiguously, never interleaved
// - Egress written contiguously into output buffer
// ----------------------------------------------------------------------
`default_nettype none

package swcore_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int          NPORT       = 6;
    localparam int          NSTK        = 3;
    localparam int          NQ          = 4;
    localparam int          BEAT_BYTES  = 8;
    localparam int          DW_BYTES    = 4;
    localparam int          QDEPTH      = 1024;
    localparam logic [2:0]  UP_PORT     = 3'h0;
    localparam logic [1:0]  Q_POST      = 2'h0;
    localparam logic [1:0]  Q_NONP      = 2'h1;
    localparam logic [1:0]  Q_CPL       = 2'h2;
    localparam logic [1:0]  Q_INS       = 2'h3;

    // ------------------------------------------------------------------
    // Buffer limits, in bytes and in beats of eight bytes
    // ------------------------------------------------------------------
    localparam int          PC_BYTES    = 4096;
    localparam int          NP_BYTES    = 768;
    localparam int          INS_DW      = 12;
    localparam int          OB_BYTES    = 4096;
    localparam int          DEC_BYTES   = 2112;
    localparam int          DEC_DEPTH   = DEC_BYTES / BEAT_BYTES;
    localparam logic [10:0] PC_BEATS    = 11'(PC_BYTES / BEAT_BYTES);
    localparam logic [10:0] NP_BEATS    = 11'(NP_BYTES / BEAT_BYTES);
    localparam logic [10:0] INS_BEATS   = 11'(INS_DW * DW_BYTES / BEAT_BYTES);
    localparam logic [10:0] OB_BEATS    = 11'(OB_BYTES / BEAT_BYTES);
    localparam logic [10:0] MAX_BEATS   = 11'(DEC_DEPTH);
    localparam logic [6:0]  TLP_LIM     = 7'h20;
    localparam logic [6:0]  INS_TLP_LIM = 7'h02;
    localparam logic [6:0]  OB_TLP_LIM  = 7'h20;

    // Advertised flow control credits per queue
    localparam int          HDR_CRED     = 32;
    localparam int          PC_DATA_CRED = 208;
    localparam int          NP_DATA_CRED = 32;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic { BUS_IDLE, BUS_MOVE } bus_state_e;

    typedef struct packed {
        logic        vld;
        logic        sof;
        logic        eof;
        logic [1:0]  q;
        logic [65:0] data;
    } ing_beat_s;

    typedef struct packed {
        logic        eof;
        logic [65:0] data;
    } beat_s;

    typedef struct packed {
        logic        vld;
        logic [2:0]  src;
        logic [2:0]  dst;
        logic [1:0]  q;
    } disp_s;

    typedef struct packed {
        logic        vld;
        logic [2:0]  port;
        logic [10:0] beats;
    } ack_s;

    typedef struct packed {
        logic        vld;
        logic        eof;
        logic        odd;
        logic [65:0] data;
    } egr_beat_s;

    // Beat limit of one input queue
    function automatic logic [10:0] ifb_beat_lim(input logic [1:0] q,
                                                 input logic       m);
        logic [10:0] b;
        unique case (q)
            Q_POST: b = PC_BEATS;
            Q_CPL:  b = PC_BEATS;
            Q_NONP: b = NP_BEATS;
            Q_INS:  b = INS_BEATS;
        endcase
        if (q == Q_INS)
            return b;
        return m ? {b[9:0], 1'b0} : b;
    endfunction

    // TLP limit of one input queue
    function automatic logic [6:0] ifb_tlp_lim(input logic [1:0] q,
                                               input logic       m);
        if (q == Q_INS)
            return INS_TLP_LIM;
        return m ? {TLP_LIM[5:0], 1'b0} : TLP_LIM;
    endfunction

    // Output buffer beat limit; descriptors do not grow when merged
    function automatic logic [10:0] ob_beat_lim(input logic m);
        return m ? {OB_BEATS[9:0], 1'b0} : OB_BEATS;
    endfunction

endpackage

`default_nettype wire

// ### switch_core_buffer_datapath.sv
// Switch core: input frame buffers, dual bus, decoupler, output accounting
`default_nettype none

module switch_core_buffer_datapath
    import swcore_pkg::*;
(
    input  wire logic                  CLK_SYS,  // Core clock
    input  wire logic                  RESET,    // Async reset, high
    input  wire logic [NSTK-1:0]       MERGE,    // Stack runs merged x8
    input  wire ing_beat_s [NSTK-1:0]  STK_ING,  // Ingress beats per stack
    input  wire disp_s                 DISP,     // Dispatch request
    input  wire ack_s                  ACK,      // Link partner ack
    output var  egr_beat_s [NSTK-1:0]  STK_EGR,  // Egress beats per stack
    output var  logic                  DISP_ACK, // Dispatch taken
    output var  logic                  DISP_NAK, // Dispatch refused
    output var  logic [NPORT-1:0]      ING_OVF,  // Ingress beat refused
    output var  logic [NPORT-1:0]      PAR_ERR   // Ingress parity error
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic                phase_q;
    logic [NPORT-1:0]    sel;
    logic [NPORT-1:0]    ok;
    logic [NPORT-1:0]    wen;
    logic [NPORT-1:0]    drop_q;
    logic [NPORT-1:0]    ob_room;
    logic [1:0]          wq      [NPORT];
    logic [9:0]          waddr   [NPORT];
    beat_s               wbeat   [NPORT];
    logic [9:0]          wp_q    [NPORT][NQ];
    logic [9:0]          rp_q    [NPORT][NQ];
    logic [10:0]         nb_q    [NPORT][NQ];
    logic [6:0]          nt_q    [NPORT][NQ];
    logic [10:0]         ob_nb_q [NPORT];
    logic [6:0]          ob_nt_q [NPORT];
    beat_s               rd_u    [NSTK];
    beat_s               rd_d;
    beat_s               u_beat;
    beat_s               d_beat;
    logic [9:0]          u_raddr;
    logic [9:0]          d_raddr;
    bus_state_e          u_st_q;
    bus_state_e          d_st_q;
    logic [2:0]          u_src_q;
    logic [1:0]          u_q_q;
    logic                u_peer_q;
    logic                d_dec_q;
    logic [1:0]          d_q_q;
    logic [2:0]          d_dst_q;
    logic                u_move;
    logic                d_move;
    beat_s               dec_mem [DEC_DEPTH];
    logic [8:0]          dec_wp_q;
    logic [8:0]          dec_rp_q;
    logic                dec_busy_q;
    logic                dec_full_q;
    logic [2:0]          dec_dst_q;
    logic [NSTK-1:0]     stk_busy;
    logic                d_launch_dec;
    logic                peer;
    logic                to_d;
    logic                legal;
    logic                avail;
    logic                busfree;
    logic                dstfree;
    logic                accept;

    // Queue address: a bifurcated port owns one half of its stack's store
    function automatic logic [9:0] qaddr(input logic [9:0] ptr,
                                         input logic       odd,
                                         input logic       m);
        return m ? ptr : {odd, ptr[8:0]};
    endfunction

    // Output buffer owner: a merged pair keeps its counts on the even port
    function automatic logic [2:0] obport(input logic [2:0]      p,
                                          input logic [NSTK-1:0] m);
        return {p[2:1], p[0] & ~m[p[2:1]]};
    endfunction

    // ------------------------------------------------------------------
    // Time division slot
    // ------------------------------------------------------------------
    // Cycle parity picks the port a bifurcated stack is presenting
    always_ff @(posedge CLK_SYS or posedge RESET)
    begin
        if (RESET)
            phase_q <= 1'b0;
        else
            phase_q <= ~phase_q;
    end

    assign u_move = (u_st_q == BUS_MOVE);
    assign d_move = (d_st_q == BUS_MOVE);

    // ------------------------------------------------------------------
    // Per port ingress, admission and accounting
    // ------------------------------------------------------------------
    for (genvar g = 0; g < NPORT; g++)
    begin : gen_port
        localparam int   S   = g / 2;
        localparam logic ODD = 1'(g % 2);
        logic [1:0]  qb;
        logic [10:0] lb;
        logic [6:0]  lt;
        logic        trunc;
        logic [65:0] dat;
        logic [2:0]  me;
        logic        ob_inc;
        logic        ob_eof;
        logic        ob_ack;

        assign qb  = STK_ING[S].q;
        assign dat = STK_ING[S].data;
        assign lb  = ifb_beat_lim(qb, MERGE[S]);
        assign lt  = ifb_tlp_lim(qb, MERGE[S]);

        // Idle slots carry no valid beat and are simply skipped
        assign sel[g] = STK_ING[S].vld &
                        (MERGE[S] ? ~ODD
                                  : (phase_q == ODD));

        // Room in the data store and, at a TLP start, in the descriptors
        assign ok[g] = (nb_q[g][qb] < lb) &
                       (STK_ING[S].sof ? (nt_q[g][qb] < lt)
                                       : ~drop_q[g]);
        // Last free beat closes the TLP so the queue never holds a tail
        assign trunc    = (nb_q[g][qb] == lb - 11'h001) & ~STK_ING[S].eof;
        assign wen[g]   = sel[g] & ok[g];
        assign wq[g]    = qb;
        assign waddr[g] = qaddr(wp_q[g][qb], ODD, MERGE[S]);
        assign wbeat[g] = '{eof: STK_ING[S].eof | trunc, data: dat};

        // Rest of a refused or truncated TLP is discarded
        always_ff @(posedge CLK_SYS or posedge RESET)
        begin
            if (RESET)
                drop_q[g] <= 1'b0;
            else if (sel[g])
                drop_q[g] <= ~STK_ING[S].eof & (~ok[g] | trunc);
        end

        // Error pulses; bad parity is reported but the beat still stored
        always_ff @(posedge CLK_SYS or posedge RESET)
        begin
            if (RESET)
            begin
                ING_OVF[g] <= 1'b0;
                PAR_ERR[g] <= 1'b0;
            end
            else
            begin
                ING_OVF[g] <= sel[g] & ~ok[g];
                PAR_ERR[g] <= sel[g] & ((^{dat[65], dat[63:32]}) |
                                        (^{dat[64], dat[31:0]}));
            end
        end

        // Four queues, each a data store plus a descriptor count
        for (genvar h = 0; h < NQ; h++)
        begin : gen_q
            logic inc;
            logic uadv;
            logic dadv;
            logic dec;
            logic dec_eof;

            assign inc  = wen[g] & (qb == 2'(h));
            assign uadv = u_move & (u_src_q == 3'(g)) & (u_q_q == 2'(h));
            assign dadv = d_move & ~d_dec_q & (g == 0) & (d_q_q == 2'(h));
            assign dec  = uadv | dadv;
            assign dec_eof = uadv ? u_beat.eof : d_beat.eof;

            always_ff @(posedge CLK_SYS or posedge RESET)
            begin
                if (RESET)
                begin
                    wp_q[g][h] <= 10'h000;
                    rp_q[g][h] <= 10'h000;
                    nb_q[g][h] <= 11'h000;
                    nt_q[g][h] <= 7'h00;
                end
                else
                begin
                    wp_q[g][h] <= wp_q[g][h] + {9'h000, inc};
                    rp_q[g][h] <= rp_q[g][h] + {9'h000, dec};
                    nb_q[g][h] <= nb_q[g][h] + {10'h000, inc}
                                             - {10'h000, dec};
                    nt_q[g][h] <= nt_q[g][h]
                                + {6'h00, inc & wbeat[g].eof}
                                - {6'h00, dec & dec_eof};
                end
            end
        end

        // Output and replay accounting: egress beats in, acks out
        assign me     = obport(3'(g), MERGE);
        assign ob_inc = (u_move & ~u_peer_q & (g == 0)) |
                        (d_move & (obport(d_dst_q, MERGE) == 3'(g)));
        assign ob_eof = (u_move & ~u_peer_q & (g == 0)) ? u_beat.eof
                                                        : d_beat.eof;
        assign ob_ack = ACK.vld & (obport(ACK.port, MERGE) == 3'(g));
        assign ob_room[g] = (ob_nb_q[me] + MAX_BEATS <=
                             ob_beat_lim(MERGE[S])) &
                            (ob_nt_q[me] < OB_TLP_LIM);

        always_ff @(posedge CLK_SYS or posedge RESET)
        begin
            if (RESET)
            begin
                ob_nb_q[g] <= 11'h000;
                ob_nt_q[g] <= 7'h00;
            end
            else
            begin
                ob_nb_q[g] <= ob_nb_q[g] + {10'h000, ob_inc}
                            - (ob_ack ? ACK.beats : 11'h000);
                ob_nt_q[g] <= ob_nt_q[g] + {6'h00, ob_inc & ob_eof}
                            - {6'h00, ob_ack};
            end
        end
    end

    // ------------------------------------------------------------------
    // Per stack input store, shared by its two ports
    // ------------------------------------------------------------------
    assign u_raddr = qaddr(rp_q[u_src_q][u_q_q], u_src_q[0],
                           MERGE[u_src_q[2:1]]);
    assign d_raddr = qaddr(rp_q[0][d_q_q], 1'b0, MERGE[0]);

    for (genvar s = 0; s < NSTK; s++)
    begin : gen_stk
        beat_s mem [NQ][QDEPTH];

        // One port per slot, so at most one write per cycle
        always_ff @(posedge CLK_SYS)
        begin
            if (wen[2*s])
                mem[wq[2*s]][waddr[2*s]] <= wbeat[2*s];
            else if (wen[2*s+1])
                mem[wq[2*s+1]][waddr[2*s+1]] <= wbeat[2*s+1];
        end

        assign rd_u[s] = mem[u_q_q][u_raddr];
        if (s == 0)
        begin : gen_up
            assign rd_d = mem[d_q_q][d_raddr];
        end
    end

    assign u_beat = rd_u[u_src_q[2:1]];
    assign d_beat = d_dec_q ? dec_mem[dec_rp_q] : rd_d;

    // ------------------------------------------------------------------
    // Dispatch decision
    // ------------------------------------------------------------------
    // An egress stack carries one TLP at a time
    always_comb
    begin
        for (int s = 0; s < NSTK; s++)
            stk_busy[s] = (u_move & ~u_peer_q & (s == 0)) |
                          (d_move & (d_dst_q[2:1] == 2'(s)));
    end

    // Decoupler drain takes the downstream bus ahead of new dispatches
    assign d_launch_dec = ~d_move & dec_full_q &
                          ~stk_busy[dec_dst_q[2:1]] & ob_room[dec_dst_q];

    assign to_d  = (DISP.src == UP_PORT);
    assign peer  = ~to_d & (DISP.dst != UP_PORT);
    assign legal = (DISP.src < 3'(NPORT)) & (DISP.dst < 3'(NPORT)) &
                   (DISP.src != DISP.dst) &
                   ~(MERGE[DISP.src[2:1]] & DISP.src[0]) &
                   ~(MERGE[DISP.dst[2:1]] & DISP.dst[0]);
    // Only whole TLPs are dispatched, so a transfer never starves
    assign avail   = (nt_q[DISP.src][DISP.q] != 7'h00);
    assign busfree = to_d ? (~d_move & ~d_launch_dec) : ~u_move;
    assign dstfree = peer ? ~dec_busy_q
                   : (~stk_busy[DISP.dst[2:1]] & ob_room[DISP.dst] &
                      ~(d_launch_dec &
                        (dec_dst_q[2:1] == DISP.dst[2:1])));
    assign accept  = DISP.vld & legal & avail & busfree & dstfree;

    always_ff @(posedge CLK_SYS or posedge RESET)
    begin
        if (RESET)
        begin
            DISP_ACK <= 1'b0;
            DISP_NAK <= 1'b0;
        end
        else
        begin
            DISP_ACK <= accept;
            DISP_NAK <= DISP.vld & ~accept;
        end
    end

    // ------------------------------------------------------------------
    // Upstream bus: downstream ports to port 0 or the decoupler
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_SYS or posedge RESET)
    begin
        if (RESET)
        begin
            u_st_q   <= BUS_IDLE;
            u_src_q  <= 3'h0;
            u_q_q    <= 2'h0;
            u_peer_q <= 1'b0;
        end
        else
        begin
            unique case (u_st_q)
                BUS_IDLE:
                    if (accept & ~to_d)
                    begin
                        u_st_q   <= BUS_MOVE;
                        u_src_q  <= DISP.src;
                        u_q_q    <= DISP.q;
                        u_peer_q <= peer;
                    end
                BUS_MOVE:
                    if (u_beat.eof)
                        u_st_q <= BUS_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Downstream bus: port 0 or the decoupler to downstream ports
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_SYS or posedge RESET)
    begin
        if (RESET)
        begin
            d_st_q  <= BUS_IDLE;
            d_dec_q <= 1'b0;
            d_q_q   <= 2'h0;
            d_dst_q <= 3'h0;
        end
        else
        begin
            unique case (d_st_q)
                BUS_IDLE:
                    if (d_launch_dec)
                    begin
                        d_st_q  <= BUS_MOVE;
                        d_dec_q <= 1'b1;
                        d_dst_q <= dec_dst_q;
                    end
                    else if (accept & to_d)
                    begin
                        d_st_q  <= BUS_MOVE;
                        d_dec_q <= 1'b0;
                        d_q_q   <= DISP.q;
                        d_dst_q <= DISP.dst;
                    end
                BUS_MOVE:
                    if (d_beat.eof)
                        d_st_q <= BUS_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Bus decoupler: one maximum size TLP
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_SYS)
    begin
        if (u_move & u_peer_q)
            dec_mem[dec_wp_q] <= u_beat;
    end

    // Reserved at dispatch so a second peer TLP cannot overrun it
    always_ff @(posedge CLK_SYS or posedge RESET)
    begin
        if (RESET)
        begin
            dec_wp_q   <= 9'h000;
            dec_rp_q   <= 9'h000;
            dec_busy_q <= 1'b0;
            dec_full_q <= 1'b0;
            dec_dst_q  <= 3'h0;
        end
        else
        begin
            if (accept & peer)
            begin
                dec_busy_q <= 1'b1;
                dec_dst_q  <= DISP.dst;
            end
            if (u_move & u_peer_q)
            begin
                dec_wp_q <= dec_wp_q + 9'h001;
                if (u_beat.eof)
                    dec_full_q <= 1'b1;
            end
            if (d_move & d_dec_q)
            begin
                dec_rp_q <= dec_rp_q + 9'h001;
                if (d_beat.eof)
                begin
                    dec_busy_q <= 1'b0;
                    dec_full_q <= 1'b0;
                    dec_wp_q   <= 9'h000;
                    dec_rp_q   <= 9'h000;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Egress beats toward the stacks' output and replay buffers
    // ------------------------------------------------------------------
    // Whole TLPs back to back; the link layer splits slots afterwards
    always_ff @(posedge CLK_SYS or posedge RESET)
    begin
        if (RESET)
            STK_EGR <= '0;
        else
        begin
            for (int s = 0; s < NSTK; s++)
            begin
                if ((s == 0) & u_move & ~u_peer_q)
                    STK_EGR[s] <= '{1'b1, u_beat.eof, 1'b0,
                                    u_beat.data};
                else if (d_move & (d_dst_q[2:1] == 2'(s)))
                    STK_EGR[s] <= '{1'b1, d_beat.eof, d_dst_q[0],
                                    d_beat.data};
                else
                    STK_EGR[s] <= '0;
            end
        end
    end

endmodule

`default_nettype wire

// ### swc_sva.sv
// Checker for dispatch answers, egress framing and ingress flags
`default_nettype none
module swc_sva
    import swcore_pkg::*;
(
    input wire logic                 CLK_SYS,  // Core clock
    input wire logic                 RESET,    // Async reset
    input wire logic [NSTK-1:0]      MERGE,    // Merged stacks
    input wire ing_beat_s [NSTK-1:0] STK_ING,  // Ingress beats
    input wire disp_s                DISP,     // Dispatch request
    input wire egr_beat_s [NSTK-1:0] STK_EGR,  // Egress beats
    input wire logic                 DISP_ACK, // Dispatch taken
    input wire logic                 DISP_NAK, // Dispatch refused
    input wire logic [NPORT-1:0]     ING_OVF,  // Beat refused
    input wire logic [NPORT-1:0]     PAR_ERR   // Parity bad
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RESET);
    // Slot phase, even on the first edge after reset
    logic ph_q;
    always_ff @(posedge CLK_SYS or posedge RESET)
        ph_q <= !RESET && !ph_q;
    chk_disp_answer: assert property (
        $past(DISP.vld) |-> DISP_ACK ^ DISP_NAK) else $error("no answer");
    chk_self_route: assert property (
        $past(DISP.vld && DISP.src == DISP.dst) |-> DISP_NAK)
        else $error("self route taken");
    chk_port_range: assert property (
        $past(DISP.vld && DISP.src > 3'h5) |-> DISP_NAK)
        else $error("bad port taken");
    chk_merged_odd: assert property (
        $past(DISP.vld && DISP.src < 3'h6 && DISP.src[0]
        && MERGE[DISP.src[2:1]]) |-> DISP_NAK) else $error("odd port taken");
    chk_ovf_cause: assert property (
        $past(!STK_ING[1].vld) |-> !ING_OVF[2]) else $error("stray overflow");
    chk_par_flag: assert property (
        !MERGE[0] && ph_q && STK_ING[0].vld
        && ^{STK_ING[0].data[64], STK_ING[0].data[31:0]} |=> PAR_ERR[1])
        else $error("parity not flagged");
    // Every egress stack keeps TLPs whole and parity even
    for (genvar s = 0; s < NSTK; s++)
    begin : g_egr
        chk_egr_contig: assert property (
            STK_EGR[s].vld && !STK_EGR[s].eof |=> STK_EGR[s].vld)
            else $error("egress gap");
        chk_egr_parity: assert property (
            STK_EGR[s].vld |-> !(^STK_EGR[s].data)
            && !(^{STK_EGR[s].data[64], STK_EGR[s].data[31:0]}))
            else $error("egress parity");
    end
endmodule
bind switch_core_buffer_datapath swc_sva i_swc_sva (.CLK_SYS(CLK_SYS),
    .RESET(RESET), .MERGE(MERGE), .STK_ING(STK_ING), .DISP(DISP),
    .STK_EGR(STK_EGR), .DISP_ACK(DISP_ACK), .DISP_NAK(DISP_NAK),
    .ING_OVF(ING_OVF), .PAR_ERR(PAR_ERR));
`default_nettype wire

// ### swc_link.sv
// Link partner model that acknowledges each egress TLP
`default_nettype none
module swc_link
    import swcore_pkg::*;
(
    input  wire logic                 CLK_SYS, // Core clock
    input  wire logic                 RESET,   // Async reset
    input  wire egr_beat_s [NSTK-1:0] STK_EGR, // Egress beats
    output var  ack_s                 ACK      // Ack pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [10:0] cnt_q [NSTK];
    // Count beats, ack after the last one; one TLP in flight is assumed
    always @(posedge CLK_SYS or posedge RESET)
    begin
        ack_s ack_d;
        ack_d = '0;
        for (int s = 0; s < NSTK; s++)
            if (RESET)
                cnt_q[s] <= '0;
            else if (STK_EGR[s].vld)
            begin
                cnt_q[s] <= STK_EGR[s].eof ? 11'h0 : cnt_q[s] + 11'h1;
                if (STK_EGR[s].eof)
                    ack_d = '{1'b1, {2'(s), STK_EGR[s].odd}, cnt_q[s] + 11'h1};
            end
        ACK <= ack_d;
    end
endmodule
`default_nettype wire

// ### switch_core_buffer_datapath_tb.sv
// Self-checking bench for the switch core datapath
`default_nettype none
module switch_core_buffer_datapath_tb import swcore_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic                 CLK_SYS = 1'b0;
    logic                 RESET = 1'b1;
    logic [NSTK-1:0]      MERGE = 3'h4;
    ing_beat_s [NSTK-1:0] STK_ING = '0;
    disp_s                DISP = '0;
    ack_s                 ACK;
    egr_beat_s [NSTK-1:0] STK_EGR;
    logic                 DISP_ACK, DISP_NAK, ph = 1'b0;
    logic [NPORT-1:0]     ING_OVF, PAR_ERR;
    logic [66:0]          exp_q[$];
    logic [65:0]          pend[$];
    int n_fail = 0, total_checks = 0, seed = 32'hc6ca, n_ovf = 0, n_par = 0;
    switch_core_buffer_datapath i_switch_core_buffer_datapath (
        .CLK_SYS(CLK_SYS), .RESET(RESET), .MERGE(MERGE), .STK_ING(STK_ING),
        .DISP(DISP), .ACK(ACK), .STK_EGR(STK_EGR), .DISP_ACK(DISP_ACK),
        .DISP_NAK(DISP_NAK), .ING_OVF(ING_OVF), .PAR_ERR(PAR_ERR));
    swc_link i_swc_link (.CLK_SYS(CLK_SYS), .RESET(RESET),
        .STK_EGR(STK_EGR), .ACK(ACK));
    initial forever #5 CLK_SYS = ~CLK_SYS;
    task automatic tick(); // ph tracks the slot parity of this edge
        @(posedge CLK_SYS);
        ph = ~ph;
    endtask
    task automatic chk(input logic [66:0] got, want);
        total_checks++;
        if (got !== want)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Send one TLP, each beat only in its port's slot
    task automatic send(input int p, input logic [1:0] q, input int n,
                        input logic bad);
        logic [65:0] d;
        for (int i = 0; i < n; i++)
        begin
            while (!MERGE[p/2] && ph == p[0])
            begin
                STK_ING[p/2].vld <= 1'b0;
                tick();
            end
            d[63:0] = {$random(seed), $random(seed)};
            d[65:64] = {^d[63:32], ^d[31:0] ^ bad};
            STK_ING[p/2] <= '{1'b1, i == 0, i == n - 1, q, d};
            pend.push_back(d);
            tick();
        end
        STK_ING[p/2].vld <= 1'b0;
        tick();
    endtask
    task automatic disp(input int src, dst, input logic [1:0] q, input ok);
        DISP <= '{1'b1, 3'(src), 3'(dst), q};
        tick();
        DISP.vld <= 1'b0;
        while (ok && pend.size())
            exp_q.push_back({1'(dst), pend.pop_front()});
        pend.delete();
        tick();
        chk(67'({DISP_ACK, DISP_NAK}), 67'({ok, !ok}));
    endtask
    // Drain, bounded; leftovers count as a mismatch
    task automatic idle(input string name);
        for (int k = 0; k < 800 && exp_q.size() > 0; k++)
            tick();
        chk(67'(exp_q.size()), 67'h0);
        if (exp_q.size() > 0)
            test_done();
        repeat (4) tick();
        $display("test %s done", name);
    endtask
    // Egress watcher takes the oldest note per beat
    always @(posedge CLK_SYS)
    begin
        n_ovf += int'(ING_OVF[2] === 1'b1);
        n_par += int'(PAR_ERR[1] === 1'b1);
        for (int s = 0; s < NSTK; s++)
            if (STK_EGR[s].vld === 1'b1)
                chk({STK_EGR[s].odd, STK_EGR[s].data},
                    exp_q.pop_front());
    end
    initial
    begin
        repeat (3) tick();
        RESET <= 1'b0;
        send(0, Q_POST, 4, 1'b0);
        disp(0, 2, Q_POST, 1'b1);
        idle("down");
        send(4, Q_NONP, 5, 1'b0);
        disp(4, 0, Q_NONP, 1'b1);
        idle("up");
        send(3, Q_CPL, 3, 1'b0);
        disp(3, 4, Q_CPL, 1'b1);
        idle("peer");
        send(1, Q_POST, 1, 1'b1);
        send(2, Q_INS, 7, 1'b0);
        tick();
        chk(67'(n_par), 67'h1);
        chk(67'(n_ovf), 67'h1);
        disp(2, 2, Q_INS, 1'b0);
        disp(6, 0, Q_POST, 1'b0);
        disp(5, 0, Q_POST, 1'b0);
        disp(1, 0, Q_NONP, 1'b0);
        idle("refuse");
        test_done();
    end
endmodule
`default_nettype wire
